/* File: bench/spm_line_model.sv */
// Behavioural line equipment at the far end of the pod.
`timescale 1ns/1ps
module spm_line_model
  import spm_pkg::*;
(
  input  wire logic       i_link_clk,
  input  wire logic       i_term,
  input  wire logic       i_on,
  input  wire logic       i_run,
  output      logic [8:0] o_line,
  output      logic [8:0] o_drv
);
  logic tgl_q = 1'b0;
  // Flips the timing and data lines each link cycle while sending.
  always @(posedge i_link_clk)
    tgl_q <= i_run & ~tgl_q;
  // Each end drives only the lines it originates; idle means all off.
  assign o_drv  = !i_on ? 9'h000 : i_term ? TERM_LINE_MASK : MODEM_LINE_MASK;
  assign o_line = !i_run ? 9'h000 : i_term ? (9'h110 | {2'h0, tgl_q, 6'h0})
                : (9'h00b | (tgl_q ? 9'h0a4 : 9'h000));
endmodule : spm_line_model

/* File: bench/spm_pod_assertions.sv */
// Checker for role decoding, driver enables and display segments.
`timescale 1ns/1ps
module spm_pod_assertions
#(
  parameter int unsigned BLINK_HALF = 8,
  parameter int unsigned ACT_HOLD   = 40
)
(
  input logic       i_clk,
  input logic       i_rst,
  input logic       i_link_clk,
  input logic       i_terminal_sim_select,
  input logic       i_modem_side_sim_select,
  input logic [8:0] i_drive_data,
  input logic [8:0] i_line_in,
  input logic [8:0] o_line_out,
  input logic [8:0] o_line_oe_n,
  input logic [8:0] o_line_rx,
  input logic [8:0] o_segment,
  input logic [1:0] o_mode
);
  localparam int BL = 2 * BLINK_HALF + 12;
  logic [15:0] stable_q;
  logic        ts;
  logic        ms;
  assign ts = i_terminal_sim_select;
  assign ms = i_modem_side_sim_select;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Counts cycles since the line levels last moved.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || $changed(i_line_in))
      stable_q <= '0;
    else if (stable_q != 16'hffff)
      stable_q <= stable_q + 16'h1;
  end
  a_monitor_tristate:
    assert property (!ts && !ms |=> o_line_oe_n == 9'h1ff && o_mode == 2'b00)
      else $error("monitor drives");
  a_both_as_monitor:
    assert property (ts && ms |=> o_line_oe_n == 9'h1ff && o_mode == 2'b00)
      else $error("both selects drive");
  a_term_enables:
    assert property (ts && !ms |=> o_line_oe_n == 9'h0af && o_mode == 2'b01)
      else $error("terminal enables");
  a_modem_enables:
    assert property (!ts && ms |=> o_line_oe_n == 9'h150 && o_mode == 2'b10)
      else $error("modem enables");
  a_drive_masked:
    assert property (o_line_out == (~o_line_oe_n & $past(i_drive_data)))
      else $error("drive level");
  a_role_held:
    assert property ($stable({ts, ms}) |=> $stable(o_mode))
      else $error("role moved");
  a_blink_seen:
    assert property ($changed(i_line_in) |-> ##[1:BL] $changed(o_segment))
      else $error("no blink");
  a_steady_level:
    assert property (stable_q == 16'(ACT_HOLD + 24)
      |-> o_segment == i_line_in && o_line_rx == i_line_in)
      else $error("steady level");
endmodule : spm_pod_assertions

/* File: bench/tb.sv */
// Self-checking bench for the pod core.
`timescale 1ns/1ps
module tb;
  localparam int unsigned AH = 40;
  localparam int unsigned BH = 8;
  logic       i_clk = 1'b0;
  logic       i_link_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       ts = 1'b0;
  logic       ms = 1'b0;
  logic       t_run = 1'b0;
  logic [8:0] drv = 9'h000;
  logic [8:0] tog = 9'h000;
  logic       flip = 1'b0;
  logic [8:0] din;
  logic [8:0] line_w, out, oe_n, rx, seg, t_line, t_drv, m_line, m_drv;
  logic [1:0] mode;
  int         failures = 0;
  int         checks = 0;
  // System clock, link clock and free-running drive toggles.
  always #4 i_clk = ~i_clk;
  initial
  begin
    #1.7;
    forever #6 i_link_clk = ~i_link_clk;
  end
  always @(posedge i_clk) flip <= ~flip;
  assign din = drv ^ (tog & {9{flip}});
  // Wire level from whichever party drives each line.
  assign line_w = (~oe_n & out) | (t_drv & t_line) | (m_drv & m_line);
  spm_pod_core #(.BLINK_HALF(BH), .ACT_HOLD(AH)) spm_pod_core_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
    .i_terminal_sim_select(ts), .i_modem_side_sim_select(ms),
    .i_drive_data(din), .i_line_in(line_w), .o_line_out(out),
    .o_line_oe_n(oe_n), .o_line_rx(rx), .o_segment(seg), .o_mode(mode));
  spm_line_model term_model (.i_link_clk(i_link_clk), .i_term(1'b1),
    .i_on(!(ts && !ms)), .i_run(t_run), .o_line(t_line), .o_drv(t_drv));
  spm_line_model modem_model (.i_link_clk(i_link_clk), .i_term(1'b0),
    .i_on(!(ms && !ts)), .i_run(1'b0), .o_line(m_line), .o_drv(m_drv));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic check(input string nm, input logic [8:0] s, e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask : check
  // Collects which segments were ever lit and which stayed lit.
  task automatic sweep(input logic [8:0] e_or, e_and);
    logic [8:0] s_or;
    logic [8:0] s_and;
    s_or = 9'h000;
    s_and = 9'h1ff;
    repeat (24)
    begin
      cyc(1);
      s_or |= seg;
      s_and &= seg;
    end
    check("lit", s_or, e_or);
    check("steady", s_and, e_and);
  endtask : sweep
  // Times the gap between two flips of one blinking segment.
  task automatic blink_gap(input int b);
    logic s;
    int   n;
    s = seg[b];
    n = 0;
    while (seg[b] === s && n < 40)
    begin
      cyc(1);
      n++;
    end
    s = seg[b];
    n = 0;
    while (seg[b] === s && n < 40)
    begin
      cyc(1);
      n++;
    end
    check("blink gap", 9'(n), 9'(BH));
  endtask : blink_gap
  task automatic test_roles();
    logic [8:0] e_oe [4] = '{9'h1ff, 9'h0af, 9'h150, 9'h1ff};
    logic [1:0] e_md [4] = '{2'b00, 2'b01, 2'b10, 2'b00};
    drv = 9'h1ff;
    for (int i = 0; i < 4; i++)
    begin
      ts = i[0];
      ms = i[1];
      cyc(1);
      check("enable", oe_n, e_oe[i]);
      check("mode", 9'(mode), 9'(e_md[i]));
      check("drive", out, ~e_oe[i]);
      cyc(1);
    end
  endtask : test_roles
  task automatic test_modem();
    ts = 1'b0;
    ms = 1'b1;
    drv = 9'h00b;
    tog = 9'h0a4;
    cyc(AH + 20);
    sweep(9'h0af, 9'h00b);
    blink_gap(2);
    tog = 9'h000;
    drv = 9'h00b;
    cyc(AH + 40);
    check("level", seg, 9'h00b);
    check("rx", rx, 9'h00b);
  endtask : test_modem
  task automatic test_monitor();
    ms = 1'b0;
    t_run = 1'b1;
    drv = 9'h1ff;
    cyc(AH + 20);
    sweep(9'h150, 9'h110);
    check("drive", out, 9'h000);
    blink_gap(6);
    t_run = 1'b0;
  endtask : test_monitor
  task automatic give_verdict();
    $display("checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Main sequence after eight cycles of reset.
  initial
  begin
    cyc(8);
    i_rst = 1'b0;
    check("reset", oe_n, 9'h1ff);
    check("reset out", out, 9'h000);
    test_roles();
    test_modem();
    test_monitor();
    give_verdict();
  end
  // Cuts a hung run short.
  initial
  begin
    cyc(20000);
    failures++;
    give_verdict();
  end
endmodule : tb
bind spm_pod_core spm_pod_assertions
  #(.BLINK_HALF(BLINK_HALF), .ACT_HOLD(ACT_HOLD)) chk_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
  .i_terminal_sim_select(i_terminal_sim_select),
  .i_modem_side_sim_select(i_modem_side_sim_select),
  .i_drive_data(i_drive_data), .i_line_in(i_line_in),
  .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n), .o_line_rx(o_line_rx),
  .o_segment(o_segment), .o_mode(o_mode));

/* File: inc/spm_link_if.sv */
// Carrier between the link-clock sampler and the system-clock core.
`timescale 1ns/1ps
interface spm_link_if #(
  parameter int unsigned WIDTH = 9
);
  logic [WIDTH-1:0] lvl;  // Line levels, registered on the link clock.
  logic [WIDTH-1:0] tgl;  // Per-line toggle, flips on each transition.

  modport link (output lvl, output tgl);
  modport core (input lvl, input tgl);
endinterface : spm_link_if

/* File: inc/spm_pkg.sv */
// Shared constants for the serial pod mode and line display logic.
package spm_pkg;

  // Number of lines shown on the status display.
  localparam int unsigned NUM_LINES = 9;

  // Bit position of each displayed line in every line vector.
  localparam int unsigned BIT_CS = 0;
  localparam int unsigned BIT_DM = 1;
  localparam int unsigned BIT_RD = 2;
  localparam int unsigned BIT_RR = 3;
  localparam int unsigned BIT_RS = 4;
  localparam int unsigned BIT_RT = 5;
  localparam int unsigned BIT_SD = 6;
  localparam int unsigned BIT_ST = 7;
  localparam int unsigned BIT_TR = 8;

  // Lines that the terminal end originates: SD, RS and TR.
  localparam logic [8:0] TERM_LINE_MASK  = 9'h150;
  // Lines that the modem end originates: CS, DM, RD, RR, RT and ST.
  localparam logic [8:0] MODEM_LINE_MASK = 9'h0af;

  // Reset values of the pin-side registers.
  localparam logic [8:0] RST_LINE_OUT  = 9'h000;
  localparam logic [8:0] RST_LINE_OE_N = 9'h1ff;
  localparam logic [8:0] RST_SEGMENT   = 9'h000;

  // System clock rate and blink timing.
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned BLINK_RATE_HZ = 2;
  // Half a blink period, in cycles, rounded down.
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_RATE_HZ);
  // Activity is held for one whole blink period after the last transition.
  localparam int unsigned ACT_HOLD_CYC = CLK_HZ / BLINK_RATE_HZ;

  // Pod roles.
  typedef enum logic [1:0]
  {
    SPM_MONITOR   = 2'b00,
    SPM_TERM_SIM  = 2'b01,
    SPM_MODEM_SIM = 2'b10
  } spm_mode_t;

endpackage : spm_pkg

/* File: src/spm_link_sampler.sv */
// Link-clock sampler: synchronises the line receivers and marks transitions.
`timescale 1ns/1ps
module spm_link_sampler
  import spm_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_LINES
)
(
  input  logic             i_link_clk,
  input  logic             i_rst,
  input  logic [WIDTH-1:0] i_line_in,
  spm_link_if.link         link
);

  //////////////////////////////////////////////////////////////////////////
  // Reset is brought into the link domain through two flip-flops.
  logic             rst_s1_q;
  logic             rst_s2_q;
  logic [WIDTH-1:0] ln_s1_q;
  logic [WIDTH-1:0] ln_s2_q;
  logic [WIDTH-1:0] ln_s3_q;
  logic [WIDTH-1:0] tgl_q;

  always_ff @(posedge i_link_clk)
  begin
    rst_s1_q <= i_rst;
    rst_s2_q <= rst_s1_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Line inputs pass two flip-flops, the third holds the previous level.
  always_ff @(posedge i_link_clk)
  begin
    ln_s1_q <= i_line_in;
    ln_s2_q <= ln_s1_q;
    ln_s3_q <= ln_s2_q;
  end

  // Each transition flips that line's toggle so it survives the crossing.
  always_ff @(posedge i_link_clk)
  begin
    if (rst_s2_q)
    begin
      tgl_q <= '0;
    end
    else
    begin
      tgl_q <= tgl_q ^ (ln_s2_q ^ ln_s3_q);
    end
  end

  assign link.lvl = ln_s3_q;
  assign link.tgl = tgl_q;

endmodule : spm_link_sampler

/* File: src/spm_pod_core.sv */
// Pod core: role select, driver enables and the blinking line display.
//
// What this block does
// - Three roles: monitor, terminal sim, modem sim.
// - Two mainframe selects configure the pod role.
// - Monitor role tristates every line driver.
// - Terminal sim enables terminal-originated line drivers.
// - Modem sim enables modem-originated line drivers.
// - Nine segments show steady line levels.
// - Transitions make a segment blink at 2Hz.
// - Toggling RD, ST, RT segments blink.
// - Steady asserted lines lit, inactive lines dark.
`timescale 1ns/1ps
module spm_pod_core
  import spm_pkg::*;
#(
  parameter int unsigned WIDTH          = NUM_LINES,
  parameter int unsigned BLINK_HALF     = BLINK_HALF_CYC,
  parameter int unsigned ACT_HOLD       = ACT_HOLD_CYC
)
(
  input  logic             i_clk,
  input  logic             i_rst,
  input  logic             i_link_clk,
  input  logic             i_terminal_sim_select,
  input  logic             i_modem_side_sim_select,
  input  logic [WIDTH-1:0] i_drive_data,
  input  logic [WIDTH-1:0] i_line_in,
  output logic [WIDTH-1:0] o_line_out,
  output logic [WIDTH-1:0] o_line_oe_n,
  output logic [WIDTH-1:0] o_line_rx,
  output logic [WIDTH-1:0] o_segment,
  output logic [1:0]       o_mode
);

  //////////////////////////////////////////////////////////////////////////
  // Parameters the logic cannot serve are refused at elaboration.
  if (WIDTH != NUM_LINES)
  begin : g_bad_width
    $error("WIDTH must equal the number of displayed lines");
  end
  if (BLINK_HALF < 1 || ACT_HOLD < 1)
  begin : g_bad_time
    $error("Blink and hold counts must be at least one cycle");
  end

  //////////////////////////////////////////////////////////////////////////
  // Declarations.
  spm_mode_t        mode_d;
  spm_mode_t        mode_q;
  logic [WIDTH-1:0] oe_n_d;
  logic [WIDTH-1:0] oe_n_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] lvl_s1_q;
  logic [WIDTH-1:0] lvl_s2_q;
  logic [WIDTH-1:0] tgl_s1_q;
  logic [WIDTH-1:0] tgl_s2_q;
  logic [WIDTH-1:0] tgl_s3_q;
  logic [WIDTH-1:0] edge_seen;
  logic [WIDTH-1:0] active;
  logic [31:0]      blink_cnt_q;
  logic             blink_phase_q;
  logic [WIDTH-1:0] seg_d;
  logic [WIDTH-1:0] seg_q;
  logic [WIDTH-1:0] rx_q;

  spm_link_if #(.WIDTH(WIDTH)) link_bus ();

  // Driver enable pattern for a role; active low, low while driving.
  function automatic logic [WIDTH-1:0] drive_oe_n(input spm_mode_t m);
    logic [WIDTH-1:0] en;
    en = '0;
    unique case (m)
      SPM_TERM_SIM:  en = TERM_LINE_MASK;
      SPM_MODEM_SIM: en = MODEM_LINE_MASK;
      SPM_MONITOR:   en = '0;
      default:       en = '0;
    endcase
    return ~en;
  endfunction : drive_oe_n

  //////////////////////////////////////////////////////////////////////////
  // Link-side sampling runs on the link's own clock.
  spm_link_sampler #(
    .WIDTH (WIDTH)
  ) u_sampler (
    .i_link_clk (i_link_clk),
    .i_rst      (i_rst),
    .i_line_in  (i_line_in),
    .link       (link_bus.link)
  );

  //////////////////////////////////////////////////////////////////////////
  // Role decode from the two mainframe selects; same clock, no sync needed.
  always_comb
  begin
    mode_d = SPM_MONITOR;
    unique case ({i_modem_side_sim_select, i_terminal_sim_select})
      2'b01:   mode_d = SPM_TERM_SIM;
      2'b10:   mode_d = SPM_MODEM_SIM;
      2'b00:   mode_d = SPM_MONITOR;
      2'b11:   mode_d = SPM_MONITOR;
      default: mode_d = SPM_MONITOR;
    endcase
  end

  // Role register.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      mode_q <= SPM_MONITOR;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Driver enables follow the decoded role in the same cycle as the role.
  always_comb
  begin
    oe_n_d = drive_oe_n(mode_d);
  end

  // Enables register; reset leaves every driver in high impedance.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      oe_n_q <= RST_LINE_OE_N;
    end
    else
    begin
      oe_n_q <= oe_n_d;
    end
  end

  // Drive levels from the mainframe, masked off on undriven lines.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      out_q <= RST_LINE_OUT;
    end
    else
    begin
      out_q <= i_drive_data & ~oe_n_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Levels and toggles cross from the link clock through two flip-flops.
  always_ff @(posedge i_clk)
  begin
    lvl_s1_q <= link_bus.lvl;
    lvl_s2_q <= lvl_s1_q;
    tgl_s1_q <= link_bus.tgl;
    tgl_s2_q <= tgl_s1_q;
    tgl_s3_q <= tgl_s2_q;
  end

  // A toggle change means at least one transition on that line.
  assign edge_seen = tgl_s2_q ^ tgl_s3_q;

  //////////////////////////////////////////////////////////////////////////
  // One hold counter per line keeps it marked active after a transition.
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_hold
    logic [31:0] hold_q;

    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        hold_q <= '0;
      end
      else if (edge_seen[g])
      begin
        hold_q <= 32'(ACT_HOLD);
      end
      else if (hold_q != '0)
      begin
        hold_q <= hold_q - 32'h0000_0001;
      end
    end

    assign active[g] = (hold_q != '0);
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared blink timebase: the phase flips every half period.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      blink_cnt_q   <= '0;
      blink_phase_q <= 1'b0;
    end
    else if (blink_cnt_q == 32'(BLINK_HALF - 1))
    begin
      blink_cnt_q   <= '0;
      blink_phase_q <= ~blink_phase_q;
    end
    else
    begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Segment choice: blink while active, otherwise the steady line level.
  always_comb
  begin
    seg_d = (active & {WIDTH{blink_phase_q}})
          | (~active & lvl_s2_q);
  end

  // Segment and received-level registers.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      seg_q <= RST_SEGMENT;
      rx_q  <= '0;
    end
    else
    begin
      seg_q <= seg_d;
      rx_q  <= lvl_s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.
  assign o_line_out  = out_q;
  assign o_line_oe_n = oe_n_q;
  assign o_line_rx   = rx_q;
  assign o_segment   = seg_q;
  assign o_mode      = mode_q;

endmodule : spm_pod_core
